// >>> fbac_pkg.sv
// constants and types for the half/full duplex async character phy
package fbac_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_HZ = 9600;
  localparam int OVS = 16;
  localparam int DIV_INT = (CLK_HZ + BAUD_HZ * OVS / 2) / (BAUD_HZ * OVS);
  localparam logic [15:0] DIV_RST = 16'(DIV_INT);
  localparam logic [3:0] OVS_LAST = 4'(OVS - 1);
  localparam logic [3:0] MID_SAMP = 4'(OVS / 2 - 1);
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic CTRL_FDX_RST = 1'h0;
  localparam int CTRL_FDX_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] IDLE_MAX = 8'hFF;
  localparam logic [7:0] IDLE_LONG = 8'h0B;
  localparam logic [7:0] IDLE_SHORT_MOD = 8'h0A;
  localparam logic [7:0] IDLE_SHORT_MIN = 8'h02;
  localparam logic [7:0] IDLE_R30 = 8'h1E;
  localparam logic [7:0] IDLE_R35 = 8'h23;
  localparam logic [7:0] IDLE_R40 = 8'h28;
  localparam logic [3:0] IDLE_REP_LAST = 4'h9;
  localparam logic [3:0] CLOSE_GAP = 4'h3;
  localparam logic [3:0] LEN_HDX = 4'hB;
  localparam logic [3:0] LEN_FDX = 4'hA;
  localparam logic [3:0] RX_LAST_HDX = 4'h9;
  localparam logic [3:0] RX_LAST_FDX = 4'h8;
  localparam logic [7:0] CH_LEAD = 8'hD7;
  localparam logic [7:0] CH_ESC = 8'hD9;
  localparam logic [7:0] CH_ESC_LEAD = 8'h00;
  localparam logic [7:0] CH_ESC_ESC = 8'h01;
  typedef enum logic [1:0] {
    REQ_OPEN_LONG, REQ_OPEN_SHORT, REQ_DATA, REQ_CLOSE
  } fbac_req_t;
  typedef enum logic [1:0] {IND_START, IND_DATA, IND_IDLE} fbac_class_t;
  typedef enum logic [2:0] {
    ST_SUCCESS, ST_FRAMING, ST_IDLE_ERR, ST_ADDR_ERR, ST_STUFF_ERR,
    ST_IDLE30, ST_IDLE35, ST_IDLE40
  } fbac_stat_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} fbac_rx_t;
endpackage

// >>> fbac_rx.sv
// oversampling character receiver
`timescale 1ns/10ps
module fbac_rx import fbac_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic samp_tick_in,
  input wire logic rx_in,
  input wire logic fdx_in,
  output logic start_out,
  output logic zero_out,
  output logic char_valid_out,
  output logic [7:0] char_data_out,
  output logic char_flag_out,
  output logic char_stop_out
);
  fbac_rx_t state_r;
  logic prev_r;
  logic [3:0] ph_r;
  logic [3:0] cnt_r;
  logic [9:0] sh_r;
  logic [9:0] sh_nxt;

  assign sh_nxt = {sh_r[8:0], rx_in};

  always_ff @(posedge clk_in) begin
    start_out <= 1'b0;
    zero_out <= 1'b0;
    char_valid_out <= 1'b0;
    if (sys_rst_in) begin
      state_r <= RX_IDLE;
      prev_r <= 1'b1;
      ph_r <= 4'h0;
      cnt_r <= 4'h0;
      sh_r <= 10'h000;
      char_data_out <= 8'h00;
      char_flag_out <= 1'b0;
      char_stop_out <= 1'b0;
    end else if (samp_tick_in) begin
      case (state_r)
        RX_IDLE: begin
          prev_r <= rx_in;
          ph_r <= 4'h0;
          if (prev_r && !rx_in) begin
            state_r <= RX_START;
          end
        end
        RX_START: begin
          ph_r <= ph_r + 4'h1;
          if (ph_r == MID_SAMP) begin
            ph_r <= 4'h0;
            cnt_r <= 4'h0;
            if (!rx_in) begin
              state_r <= RX_BITS;
              start_out <= 1'b1;
              zero_out <= 1'b1;
            end else begin
              state_r <= RX_IDLE;
            end
          end
        end
        RX_BITS: begin
          ph_r <= ph_r + 4'h1;
          if (ph_r == OVS_LAST) begin
            ph_r <= 4'h0;
            sh_r <= sh_nxt;
            zero_out <= !rx_in;
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == (fdx_in ? RX_LAST_FDX : RX_LAST_HDX)) begin
              state_r <= RX_IDLE;
              prev_r <= rx_in;
              char_valid_out <= 1'b1;
              char_stop_out <= rx_in;
              if (fdx_in) begin
                char_data_out <= sh_nxt[8:1];
                char_flag_out <= 1'b0;
              end else begin
                char_data_out <= sh_nxt[9:2];
                char_flag_out <= sh_nxt[1];
              end
            end
          end
        end
        default: state_r <= RX_IDLE;
      endcase
    end
  end
endmodule // fbac_rx

// >>> fbac_phy.sv
// async character phy with axi4-lite control
`timescale 1ns/10ps
module fbac_phy import fbac_pkg::*; (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_kind_in,
  input wire logic [7:0] req_data_in,
  output logic req_ack_out,
  output logic ind_valid_out,
  output logic [1:0] ind_class_out,
  output logic [2:0] ind_status_out,
  output logic [7:0] ind_data_out,
  input wire logic line_rx_in,
  output logic line_tx_out,
  output logic line_drive_enable_out,
  input wire logic cts_in,
  output logic rts_out
);
  logic fdx_r;
  logic [15:0] div_r;
  logic [15:0] div_cnt_r;
  logic samp_tick_r;
  logic [3:0] bph_r;
  logic bit_tick;
  logic rx_m_r, rx_s_r, cts_m_r, cts_s_r;
  logic rx_start, rx_zero, rx_valid, rx_flag, rx_stop;
  logic [7:0] rx_data;
  logic [7:0] idle_r;
  logic [7:0] idle_snap_r;
  logic [7:0] idle_inc;
  logic [3:0] rep_r;
  logic [10:0] sh_r;
  logic [3:0] left_r;
  logic tx_on_r;
  logic tx_bit;
  logic load;
  logic go;
  logic [1:0] pend_r;
  logic [10:0] pend0_r, pend1_r;
  logic [3:0] gap_r;
  logic take;
  logic lead_r, esc_r;
  logic [31:0] rd_mux;
  logic rd_err;

  function automatic logic [10:0] mk_char(input logic [7:0] d,
                                          input logic flag,
                                          input logic fdx);
    if (fdx) begin
      mk_char = {1'b0, d, 1'b1, 1'b0};
    end else begin
      mk_char = {1'b0, d, flag, 1'b1};
    end
  endfunction

  // input synchronisers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      cts_m_r <= 1'b0;
      cts_s_r <= 1'b0;
    end else begin
      rx_m_r <= line_rx_in;
      rx_s_r <= rx_m_r;
      cts_m_r <= cts_in;
      cts_s_r <= cts_m_r;
    end
  end

  // sample and bit rate enables
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      div_cnt_r <= 16'h0000;
      samp_tick_r <= 1'b0;
      bph_r <= 4'h0;
    end else begin
      samp_tick_r <= 1'b0;
      if (div_cnt_r >= ((div_r == 16'h0000) ? 16'h0000 : div_r - 16'h1))
      begin
        div_cnt_r <= 16'h0000;
        samp_tick_r <= 1'b1;
      end else begin
        div_cnt_r <= div_cnt_r + 16'h1;
      end
      if (samp_tick_r) begin
        bph_r <= bph_r + 4'h1;
      end
    end
  end

  assign bit_tick = samp_tick_r && (bph_r == OVS_LAST);

  fbac_rx u_rx (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .samp_tick_in(samp_tick_r),
    .rx_in(rx_s_r),
    .fdx_in(fdx_r),
    .start_out(rx_start),
    .zero_out(rx_zero),
    .char_valid_out(rx_valid),
    .char_data_out(rx_data),
    .char_flag_out(rx_flag),
    .char_stop_out(rx_stop)
  );

  // transmit shifter
  assign go = fdx_r ? cts_s_r : 1'b1;
  assign load = bit_tick && (left_r == 4'h0) && (pend_r != 2'h0) && go;

  always_comb begin
    if (left_r != 4'h0) begin
      tx_bit = sh_r[10];
    end else if (load) begin
      tx_bit = pend0_r[10];
    end else begin
      tx_bit = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      line_tx_out <= 1'b1;
      sh_r <= 11'h7FF;
      left_r <= 4'h0;
      tx_on_r <= 1'b0;
    end else if (bit_tick) begin
      line_tx_out <= tx_bit;
      if (left_r != 4'h0) begin
        sh_r <= {sh_r[9:0], 1'b0};
        left_r <= left_r - 4'h1;
      end else if (load) begin
        sh_r <= {pend0_r[9:0], 1'b0};
        left_r <= (fdx_r ? LEN_FDX : LEN_HDX) - 4'h1;
        tx_on_r <= 1'b1;
      end else begin
        tx_on_r <= 1'b0;
      end
    end
  end

  // request acceptance
  always_comb begin
    take = 1'b0;
    if (req_valid_in && !req_ack_out) begin
      case (fbac_req_t'(req_kind_in))
        REQ_OPEN_LONG: begin
          if (fdx_r) begin
            take = (pend_r == 2'h0) && !tx_on_r;
          end else begin
            take = (pend_r == 2'h0) && (idle_r >= IDLE_LONG);
          end
        end
        REQ_OPEN_SHORT: begin
          if (fdx_r) begin
            take = (pend_r == 2'h0) && !tx_on_r;
          end else begin
            take = (pend_r == 2'h0) &&
                   ((idle_r % IDLE_SHORT_MOD) >= IDLE_SHORT_MIN);
          end
        end
        REQ_DATA: take = (pend_r == 2'h0);
        REQ_CLOSE: begin
          take = (pend_r == 2'h0) && !tx_on_r &&
                 (fdx_r || (gap_r >= CLOSE_GAP));
        end
        default: take = 1'b0;
      endcase
    end
  end

  // pending characters
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pend_r <= 2'h0;
      pend0_r <= 11'h7FF;
      pend1_r <= 11'h7FF;
    end else if (take && req_kind_in != REQ_CLOSE) begin
      pend_r <= 2'h1;
      pend0_r <= mk_char(req_data_in, req_kind_in != REQ_DATA, fdx_r);
      if (fdx_r && req_kind_in != REQ_DATA) begin
        pend_r <= 2'h2;
        pend0_r <= mk_char(CH_LEAD, 1'b0, 1'b1);
        pend1_r <= mk_char(req_data_in, 1'b0, 1'b1);
      end else if (fdx_r && req_data_in == CH_LEAD) begin
        pend_r <= 2'h2;
        pend0_r <= mk_char(CH_ESC, 1'b0, 1'b1);
        pend1_r <= mk_char(CH_ESC_LEAD, 1'b0, 1'b1);
      end else if (fdx_r && req_data_in == CH_ESC) begin
        pend_r <= 2'h2;
        pend0_r <= mk_char(CH_ESC, 1'b0, 1'b1);
        pend1_r <= mk_char(CH_ESC_ESC, 1'b0, 1'b1);
      end
    end else if (load) begin
      pend_r <= pend_r - 2'h1;
      pend0_r <= pend1_r;
    end
  end

  // acknowledge, drive enable, rts, close gap
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      req_ack_out <= 1'b0;
      line_drive_enable_out <= 1'b0;
      rts_out <= 1'b0;
      gap_r <= 4'h0;
    end else begin
      req_ack_out <= take;
      if (take) begin
        case (fbac_req_t'(req_kind_in))
          REQ_OPEN_LONG, REQ_OPEN_SHORT: begin
            if (fdx_r) begin
              rts_out <= 1'b1;
            end else begin
              line_drive_enable_out <= 1'b1;
            end
          end
          REQ_CLOSE: begin
            line_drive_enable_out <= 1'b0;
            rts_out <= 1'b0;
          end
          default: gap_r <= gap_r;
        endcase
      end
      if (tx_on_r || pend_r != 2'h0) begin
        gap_r <= 4'h0;
      end else if (bit_tick && gap_r < CLOSE_GAP) begin
        gap_r <= gap_r + 4'h1;
      end
    end
  end

  // idle counter and link idle reports
  assign idle_inc = (idle_r == IDLE_MAX) ? IDLE_MAX : idle_r + 8'h1;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      idle_r <= 8'h00;
      rep_r <= 4'h0;
      idle_snap_r <= 8'h00;
    end else begin
      if (rx_start) begin
        idle_snap_r <= idle_r;
      end
      if (rx_zero) begin
        idle_r <= 8'h00;
      end else if (bit_tick) begin
        if (!tx_bit) begin
          idle_r <= 8'h00;
        end else begin
          idle_r <= idle_inc;
        end
      end
      if (bit_tick && tx_bit && !rx_zero) begin
        if (idle_inc == IDLE_R40 && idle_r != IDLE_MAX) begin
          rep_r <= 4'h0;
        end else if (idle_r >= IDLE_R40) begin
          rep_r <= (rep_r == IDLE_REP_LAST) ? 4'h0 : rep_r + 4'h1;
        end
      end
    end
  end

  // indications to the link layer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ind_valid_out <= 1'b0;
      ind_class_out <= IND_DATA;
      ind_status_out <= ST_SUCCESS;
      ind_data_out <= 8'h00;
      lead_r <= 1'b0;
      esc_r <= 1'b0;
    end else begin
      ind_valid_out <= 1'b0;
      if (rx_valid) begin
        ind_valid_out <= 1'b1;
        ind_data_out <= rx_data;
        ind_class_out <= IND_DATA;
        ind_status_out <= rx_stop ? ST_SUCCESS : ST_FRAMING;
        if (!fdx_r) begin
          lead_r <= 1'b0;
          esc_r <= 1'b0;
          if (rx_flag || idle_snap_r >= IDLE_LONG) begin
            ind_class_out <= IND_START;
            if (!rx_stop) begin
              ind_status_out <= ST_FRAMING;
            end else if (!rx_flag) begin
              ind_status_out <= ST_ADDR_ERR;
            end else if (idle_snap_r < IDLE_LONG) begin
              ind_status_out <= ST_IDLE_ERR;
            end
          end
        end else if (lead_r) begin
          lead_r <= 1'b0;
          ind_class_out <= IND_START;
        end else if (esc_r) begin
          esc_r <= 1'b0;
          if (!rx_stop) begin
            ind_status_out <= ST_FRAMING;
          end else if (rx_data == CH_ESC_LEAD) begin
            ind_data_out <= CH_LEAD;
          end else if (rx_data == CH_ESC_ESC) begin
            ind_data_out <= CH_ESC;
          end else begin
            ind_status_out <= ST_STUFF_ERR;
          end
        end else if (rx_data == CH_LEAD) begin
          ind_valid_out <= 1'b0;
          lead_r <= 1'b1;
        end else if (rx_data == CH_ESC && rx_stop) begin
          ind_valid_out <= 1'b0;
          esc_r <= 1'b1;
        end
      end else if (bit_tick && tx_bit && !rx_zero && idle_r != IDLE_MAX) begin
        ind_data_out <= 8'h00;
        ind_class_out <= IND_IDLE;
        if (idle_inc == IDLE_R30) begin
          ind_valid_out <= 1'b1;
          ind_status_out <= ST_IDLE30;
        end else if (idle_inc == IDLE_R35) begin
          ind_valid_out <= 1'b1;
          ind_status_out <= ST_IDLE35;
        end else if (idle_inc == IDLE_R40 ||
                     (idle_r > IDLE_R40 && rep_r == IDLE_REP_LAST)) begin
          ind_valid_out <= 1'b1;
          ind_status_out <= ST_IDLE40;
        end
      end else if (bit_tick && idle_r == IDLE_MAX && rep_r == IDLE_REP_LAST
                   && tx_bit && !rx_zero) begin
        ind_valid_out <= 1'b1;
        ind_class_out <= IND_IDLE;
        ind_status_out <= ST_IDLE40;
        ind_data_out <= 8'h00;
      end
    end
  end

  // axi4-lite write channel
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      fdx_r <= CTRL_FDX_RST;
      div_r <= DIV_RST;
    end else begin
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      if (s_axi_awready_out) begin
        s_axi_awready_out <= 1'b0;
        s_axi_wready_out <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= RESP_OKAY;
        if (s_axi_awaddr_in[7:2] == ADDR_CTRL[7:2]) begin
          if (s_axi_wstrb_in[0]) begin
            fdx_r <= s_axi_wdata_in[CTRL_FDX_BIT];
          end
        end else if (s_axi_awaddr_in[7:2] == ADDR_DIV[7:2]) begin
          if (s_axi_wstrb_in[0]) begin
            div_r[7:0] <= s_axi_wdata_in[7:0];
          end
          if (s_axi_wstrb_in[1]) begin
            div_r[15:8] <= s_axi_wdata_in[15:8];
          end
        end else if (s_axi_awaddr_in[7:2] != ADDR_STAT[7:2]) begin
          s_axi_bresp_out <= RESP_SLVERR;
        end
      end else if (s_axi_awvalid_in && s_axi_wvalid_in &&
                   !s_axi_bvalid_out) begin
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (s_axi_araddr_in[7:2] == ADDR_CTRL[7:2]) begin
      rd_mux[CTRL_FDX_BIT] = fdx_r;
    end else if (s_axi_araddr_in[7:2] == ADDR_DIV[7:2]) begin
      rd_mux[15:0] = div_r;
    end else if (s_axi_araddr_in[7:2] == ADDR_STAT[7:2]) begin
      rd_mux[15:0] = {idle_r, 5'h00, tx_on_r, rts_out,
                      line_drive_enable_out};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end else begin
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
      if (s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_mux;
        s_axi_rresp_out <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
      end
    end
  end
endmodule // fbac_phy

// >>> fbac_mau_model.sv
// line driver model: pulled-up line, echo while rts, slow clear-to-send
`timescale 1ns/10ps
module fbac_line_drv_model #(
  parameter int CTS_DLY = 40
) (
  input wire logic clk_in,
  input wire logic line_tx_in,
  input wire logic rts_in,
  input wire logic inj_in,
  output logic line_rx_out,
  output logic cts_out
);
  int cnt = 0;
  logic cts_r = 1'h0;
  // far end echoes in full duplex; injected zeros override the echo
  assign line_rx_out = inj_in & (rts_in === 1'h1 ? line_tx_in : 1'h1);
  assign cts_out = cts_r;
  always @(posedge clk_in) begin
    cnt <= rts_in === 1'h1 ? (cnt < CTS_DLY ? cnt + 1 : cnt) : 0;
    cts_r <= rts_in === 1'h1 && cnt >= CTS_DLY;
  end
endmodule // fbac_line_drv_model

// >>> fbac_phy_asserts.sv
// assertions on the character phy top ports
`timescale 1ns/10ps
module fbac_phy_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_kind_in,
  input wire logic req_ack_out,
  input wire logic ind_valid_out,
  input wire logic [1:0] ind_class_out,
  input wire logic [2:0] ind_status_out,
  input wire logic [7:0] ind_data_out,
  input wire logic line_tx_out,
  input wire logic line_drive_enable_out,
  input wire logic cts_in,
  input wire logic rts_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  ack_pulse_a: assert property (req_ack_out |=> !req_ack_out)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (req_ack_out |-> $past(req_valid_in))
    else $error("ack without a request");
  open_enable_a: assert property ($rose(line_drive_enable_out)
    |-> req_ack_out && $past(req_kind_in) <= 2'h1)
    else $error("drive enable not raised by an open");
  close_line_a: assert property ($fell(line_drive_enable_out) |->
    line_tx_out && $past(line_tx_out, 2))
    else $error("drive enable dropped inside a character");
  idle_line_a: assert property (!line_drive_enable_out && !rts_out |->
    line_tx_out)
    else $error("line not high while undriven");
  cts_gate_a: assert property (rts_out && !cts_in && !$past(cts_in) &&
    !$past(cts_in, 2) && !$past(cts_in, 3) && $past(line_tx_out) |->
    line_tx_out)
    else $error("character started without cts");
  ind_pulse_a: assert property (ind_valid_out |=> !ind_valid_out)
    else $error("indication longer than one cycle");
  idle_rep_a: assert property (ind_valid_out && ind_class_out == 2'h2
    |-> ind_data_out == 8'h00 && ind_status_out >= 3'h5)
    else $error("bad idle report");
  rts_open_a: assert property ($rose(rts_out) |-> req_ack_out)
    else $error("rts raised without ack");
  cover property (req_ack_out && $past(req_kind_in) == 2'h3);
  cover property (ind_valid_out && ind_class_out == 2'h2);
  cover property ($rose(rts_out));
endmodule // fbac_phy_chk
bind fbac_phy fbac_phy_chk u_chk (.*);

// >>> fbac_phy_tb.sv
// self-checking bench for the character phy
`timescale 1ns/10ps
module fbac_phy_tb import fbac_pkg::*; ;
  localparam int BIT = 16;
  logic clk_in = 1'h0, sys_rst_in = 1'h1;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
  logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
  logic s_axi_rready_in = 1'h0, req_valid_in = 1'h0;
  logic [1:0] req_kind_in = 2'h0;
  logic [7:0] req_data_in = 8'h00;
  logic line_rx_in, cts_in, inj_b = 1'h1, keep_idle = 1'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, req_ack_out, ind_valid_out;
  logic line_tx_out, line_drive_enable_out, rts_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, ind_class_out;
  logic [2:0] ind_status_out;
  logic [7:0] ind_data_out;
  logic [31:0] s_axi_rdata_out;
  logic [12:0] q[$];
  int num_errors = 0, checks_done = 0, hi_cnt = 0;

  fbac_phy dut (.*);
  fbac_line_drv_model #(.CTS_DLY(40)) drv (.clk_in(clk_in),
    .line_tx_in(line_tx_out), .rts_in(rts_out), .inj_in(inj_b),
    .line_rx_out(line_rx_in), .cts_out(cts_in));

  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    hi_cnt <= line_tx_out ? hi_cnt + 1 : 0;
    if (ind_valid_out === 1'h1 && (keep_idle || ind_class_out !== IND_IDLE))
      q.push_back({ind_class_out, ind_status_out, ind_data_out});
  end

  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic expq(input fbac_class_t c, input fbac_stat_t s,
                      input logic [7:0] d);
    logic [12:0] v;
    v = q.size() > 0 ? q.pop_front() : 13'h1FFF;
    chk(v, {c, s, d});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out === 1'h1) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out === 1'h1) s_axi_wvalid_in <= 1'h0;
    end while (s_axi_bvalid_out !== 1'h1);
    s_axi_bready_in <= 1'h0;
    chk(s_axi_bresp_out, er);
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out === 1'h1) s_axi_arvalid_in <= 1'h0;
    end while (s_axi_rvalid_out !== 1'h1);
    s_axi_rready_in <= 1'h0;
    chk(s_axi_rdata_out, e);
    chk(s_axi_rresp_out, er);
    @(posedge clk_in);
  endtask

  task automatic req(input fbac_req_t k, input logic [7:0] d);
    req_kind_in <= k;
    req_data_in <= d;
    req_valid_in <= 1'h1;
    for (int n = 0; n < 4000; n++) begin
      @(posedge clk_in);
      if (req_ack_out === 1'h1) break;
    end
    req_valid_in <= 1'h0;
    chk(req_ack_out, 1'h1);
    @(posedge clk_in);
  endtask

  // samples 22 transmitted bits mid-bit from the first start bit
  task automatic grab(output logic [31:0] w);
    w = 32'h0;
    for (int n = 0; n < 4000 && line_tx_out !== 1'h0; n++) @(posedge clk_in);
    repeat (8) @(posedge clk_in);
    repeat (22) begin
      w = {w[30:0], line_tx_out};
      repeat (BIT) @(posedge clk_in);
    end
  endtask

  task automatic send(input logic [10:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      inj_b <= w[i];
      repeat (BIT) @(posedge clk_in);
    end
  endtask

  task automatic regs();
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    rd(ADDR_DIV, {16'h0, DIV_RST}, RESP_OKAY);
    wr(ADDR_DIV, 32'h1, RESP_OKAY);
    rd(ADDR_DIV, 32'h1, RESP_OKAY);
    wr(ADDR_STAT, 32'hFFFF, RESP_OKAY);
    wr(8'h0C, 32'h5, RESP_SLVERR);
    rd(8'h0C, 32'h0, RESP_SLVERR);
  endtask

  task automatic hdx_frame();
    logic [31:0] w;
    keep_idle = 1'h1;
    req(REQ_OPEN_LONG, 8'hA5);
    fork
      grab(w);
      req(REQ_DATA, 8'h3C);
    join
    chk(w, {1'h0, 8'hA5, 2'h3, 1'h0, 8'h3C, 2'h1});
    req(REQ_CLOSE, 8'h00);
    chk(hi_cnt >= 64 && hi_cnt <= 180, 1'h1);
    chk(line_drive_enable_out, 1'h0);
    repeat (52 * BIT) @(posedge clk_in);
    expq(IND_IDLE, ST_IDLE30, 8'h00);
    expq(IND_IDLE, ST_IDLE35, 8'h00);
    expq(IND_IDLE, ST_IDLE40, 8'h00);
    expq(IND_IDLE, ST_IDLE40, 8'h00);
    keep_idle = 1'h0;
    req(REQ_OPEN_SHORT, 8'h0F);
    req(REQ_CLOSE, 8'h00);
  endtask

  task automatic hdx_rx();
    repeat (12 * BIT) @(posedge clk_in);
    send({1'h0, 8'h5A, 2'h1}, 11);
    send({1'h0, 8'hC3, 2'h3}, 11);
    send({1'h0, 8'h81, 2'h1}, 11);
    send({1'h0, 8'h7E, 2'h0}, 11);
    inj_b <= 1'h1;
    repeat (20 * BIT) @(posedge clk_in);
    send({1'h0, 8'h99, 2'h2}, 11);
    inj_b <= 1'h1;
    repeat (14 * BIT) @(posedge clk_in);
    send({1'h0, 8'h6B, 2'h3}, 11);
    inj_b <= 1'h1;
    repeat (2 * BIT) @(posedge clk_in);
    expq(IND_START, ST_ADDR_ERR, 8'h5A);
    expq(IND_START, ST_IDLE_ERR, 8'hC3);
    expq(IND_DATA, ST_SUCCESS, 8'h81);
    expq(IND_DATA, ST_FRAMING, 8'h7E);
    expq(IND_START, ST_FRAMING, 8'h99);
    expq(IND_START, ST_SUCCESS, 8'h6B);
  endtask

  task automatic fdx_frame();
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    req(REQ_OPEN_SHORT, 8'h12);
    chk(rts_out, 1'h1);
    req(REQ_DATA, 8'hD7);
    req(REQ_DATA, 8'hD9);
    req(REQ_DATA, 8'h55);
    req(REQ_CLOSE, 8'h00);
    chk(rts_out, 1'h0);
    repeat (2 * BIT) @(posedge clk_in);
    expq(IND_START, ST_SUCCESS, 8'h12);
    expq(IND_DATA, ST_SUCCESS, 8'hD7);
    expq(IND_DATA, ST_SUCCESS, 8'hD9);
    expq(IND_DATA, ST_SUCCESS, 8'h55);
  endtask

  task automatic fdx_rx();
    send({1'h0, 8'hD9, 1'h1}, 10);
    send({1'h0, 8'h33, 1'h1}, 10);
    send({1'h0, 8'hD7, 1'h1}, 10);
    send({1'h0, 8'h44, 1'h0}, 10);
    inj_b <= 1'h1;
    repeat (2 * BIT) @(posedge clk_in);
    expq(IND_DATA, ST_STUFF_ERR, 8'h33);
    expq(IND_START, ST_FRAMING, 8'h44);
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    @(posedge clk_in);
    chk({line_tx_out, line_drive_enable_out, rts_out}, 3'h4);
    regs();
    hdx_frame();
    hdx_rx();
    fdx_frame();
    fdx_rx();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk_in);
    num_errors++;
    test_done();
  end
endmodule // fbac_phy_tb
